/* File: design/dta_top.sv */
// Trigger, arming and halt-request controller with AXI4-Lite registers
`timescale 1ns/1ps
module dta_top #(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 8,
  parameter int DEPTH = dta_pkg::DTA_DEPTH
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [ADDR_W-1:0] core_addr,
  input wire logic [DATA_W-1:0] core_data,
  input wire logic core_bus_valid,
  input wire logic [1:0] core_cof,
  input wire logic opcode_exec_a,
  input wire logic opcode_exec_b,
  output logic store_valid,
  output logic [ADDR_W-1:0] store_value,
  output logic store_event_data,
  output logic halt_force,
  output logic halt_tag
);
  localparam int CNT_W = $clog2(DEPTH + 1);
  default clocking dta_cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] trig_reg, trig_next;
  logic [3:0] mode_reg, mode_next;
  logic [ADDR_W-1:0] cmpa_reg, cmpa_next, cmpb_reg, cmpb_next;
  logic af_reg, af_next, bf_reg, bf_next, cf_reg, cf_next;
  logic capture_active_flag_reg, capture_active_flag_next, seq_reg, seq_next, trig_seen_reg, trig_seen_next;
  logic [CNT_W-1:0] count_reg, count_next;
  logic store_valid_next, store_event_next, halt_force_next, halt_tag_next;
  logic [ADDR_W-1:0] store_value_next, prev_addr_reg;
  logic aw_got_reg, aw_got_next, w_got_reg, w_got_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [31:0] wbyte_reg, wbyte_next;
  logic wstrb0_reg, wstrb0_next;
  logic bvalid_next, rvalid_next;
  logic [1:0] bresp_next, rresp_next;
  logic [31:0] rdata_next;

  logic enable, armed, begin_type, qual, tag, brk;
  logic a_hit, b_hit, a_trig, b_trig, set_a, set_b, trigger, event_mode;
  logic wr_fire, wr_ctrl, arm_write, disarm_write, full;
  logic reset_keep;

  function automatic logic is_event(input logic [3:0] m);
    is_event = (m == dta_pkg::DTA_MODE_EVENT_B) ||
               (m == dta_pkg::DTA_MODE_A_THEN_EVB);
  endfunction

  function automatic logic is_full_mode(input logic [3:0] m);
    is_full_mode = (m == dta_pkg::DTA_MODE_A_AND_B) ||
                   (m == dta_pkg::DTA_MODE_A_AND_NB);
  endfunction

  assign enable = ctrl_reg[dta_pkg::DTA_C_EN];
  assign armed = capture_active_flag_reg;
  assign tag = ctrl_reg[dta_pkg::DTA_C_TAG];
  assign brk = ctrl_reg[dta_pkg::DTA_C_BRK];
  assign qual = trig_reg[dta_pkg::DTA_T_QUAL];
  assign event_mode = is_event(mode_reg);
  // Event-only modes force begin-type regardless of the begin bit
  assign begin_type = trig_reg[dta_pkg::DTA_T_BEGIN] || event_mode;
  assign full = count_reg == CNT_W'(DEPTH);

  // Comparator hits; full modes compare B to the data bus
  always_comb begin
    a_hit = core_bus_valid && (core_addr == cmpa_reg);
    b_hit = core_bus_valid && (core_addr == cmpb_reg);
    if (is_full_mode(mode_reg)) begin
      b_hit = core_bus_valid &&
              (core_data == cmpb_reg[DATA_W-1:0]);
    end
  end

  // Opcode qualification passes a hit only once execution is confirmed, except comparator B in event modes
  assign a_trig = qual ? (a_hit && opcode_exec_a) : a_hit;
  assign b_trig = (qual && !event_mode) ?
                  (b_hit && opcode_exec_b) : b_hit;

  always_comb begin
    set_a = 1'b0;
    set_b = 1'b0;
    seq_next = seq_reg;
    case (mode_reg)
      dta_pkg::DTA_MODE_A_ONLY: set_a = a_trig;
      dta_pkg::DTA_MODE_A_OR_B: begin
        set_a = a_trig;
        set_b = b_trig;
      end
      dta_pkg::DTA_MODE_A_THEN_B, dta_pkg::DTA_MODE_A_THEN_EVB: begin
        set_a = a_trig && !seq_reg;
        set_b = b_trig && seq_reg;
        if (a_trig) begin
          seq_next = 1'b1;
        end
      end
      dta_pkg::DTA_MODE_EVENT_B: set_b = b_trig;
      dta_pkg::DTA_MODE_A_AND_B: begin
        set_a = a_trig && b_hit;
        set_b = a_trig && b_hit;
      end
      dta_pkg::DTA_MODE_A_AND_NB: begin
        set_a = a_trig && core_bus_valid && !b_hit;
        set_b = a_trig && core_bus_valid && !b_hit;
      end
      dta_pkg::DTA_MODE_INSIDE: begin
        set_a = core_bus_valid && core_addr >= cmpa_reg &&
                core_addr <= cmpb_reg;
        set_b = set_a;
      end
      dta_pkg::DTA_MODE_OUTSIDE: begin
        set_a = core_bus_valid && core_addr < cmpa_reg;
        set_b = core_bus_valid && core_addr > cmpb_reg;
      end
      default: begin
        set_a = 1'b0;
        set_b = 1'b0;
      end
    endcase
    if (!armed || arm_write) begin
      set_a = 1'b0;
      set_b = 1'b0;
      seq_next = 1'b0;
    end
  end

  always_comb begin
    case (mode_reg)
      dta_pkg::DTA_MODE_A_ONLY: trigger = set_a;
      dta_pkg::DTA_MODE_A_OR_B, dta_pkg::DTA_MODE_OUTSIDE:
        trigger = set_a || set_b;
      dta_pkg::DTA_MODE_A_THEN_B, dta_pkg::DTA_MODE_A_THEN_EVB,
      dta_pkg::DTA_MODE_EVENT_B: trigger = set_b;
      dta_pkg::DTA_MODE_A_AND_B, dta_pkg::DTA_MODE_A_AND_NB:
        // Tagged halts in end runs follow comparator one only
        trigger = (tag && !begin_type) ? a_trig : set_a;
      default: trigger = set_a && set_b;
    endcase
  end

  // Register write decode
  assign wr_fire = aw_got_reg && w_got_reg && !s_axi_bvalid;
  assign wr_ctrl = wr_fire && wstrb0_reg &&
                   (awaddr_reg == dta_pkg::DTA_OFF_CTRL);
  assign arm_write = wr_ctrl && wbyte_reg[dta_pkg::DTA_C_EN] &&
                     wbyte_reg[dta_pkg::DTA_C_ARM];
  assign disarm_write = wr_ctrl && !wbyte_reg[dta_pkg::DTA_C_ARM];
  assign reset_keep = enable && !trig_reg[dta_pkg::DTA_T_BEGIN];

  always_comb begin
    ctrl_next = ctrl_reg;
    trig_next = trig_reg;
    mode_next = mode_reg;
    cmpa_next = cmpa_reg;
    cmpb_next = cmpb_reg;
    af_next = af_reg || set_a;
    bf_next = bf_reg || set_b;
    cf_next = cf_reg;
    capture_active_flag_next = capture_active_flag_reg;
    trig_seen_next = trig_seen_reg;
    count_next = count_reg;
    store_valid_next = 1'b0;
    store_event_next = event_mode;
    store_value_next = store_value;
    halt_force_next = 1'b0;
    halt_tag_next = 1'b0;
    if (armed) begin
      if (event_mode) begin
        if (set_b) begin
          store_valid_next = 1'b1;
          store_value_next = ADDR_W'(core_data);
        end
      end else if ((!begin_type || trig_seen_reg || trigger) &&
                   core_cof != 2'h0) begin
        store_valid_next = 1'b1;
        store_value_next = core_cof[1] ? core_addr :
                           ADDR_W'(prev_addr_reg - ADDR_W'(2));
      end
      if (store_valid_next && !full) begin
        count_next = CNT_W'(count_reg + CNT_W'(1));
      end
      if (trigger) begin
        trig_seen_next = 1'b1;
      end
      if (!begin_type && trigger) begin
        capture_active_flag_next = 1'b0;
        ctrl_next[dta_pkg::DTA_C_ARM] = 1'b0;
        halt_force_next = brk && !tag;
        halt_tag_next = brk && tag;
      end
      if (begin_type && store_valid_next &&
          count_reg == CNT_W'(DEPTH - 1)) begin
        capture_active_flag_next = 1'b0;
        ctrl_next[dta_pkg::DTA_C_ARM] = 1'b0;
        halt_force_next = brk;
      end
    end
    if (wr_fire && wstrb0_reg) begin
      case (awaddr_reg)
        dta_pkg::DTA_OFF_CTRL: ctrl_next = wbyte_reg[7:0];
        dta_pkg::DTA_OFF_TRIG: begin
          trig_next = {wbyte_reg[7:6], 6'h00};
          mode_next = wbyte_reg[3:0] > dta_pkg::DTA_MODE_LAST ?
                      dta_pkg::DTA_MODE_A_ONLY : wbyte_reg[3:0];
        end
        dta_pkg::DTA_OFF_CMPA: cmpa_next = ADDR_W'(wbyte_reg);
        dta_pkg::DTA_OFF_CMPB: cmpb_next = ADDR_W'(wbyte_reg);
        default: ctrl_next = ctrl_reg;
      endcase
    end
    if (arm_write) begin
      capture_active_flag_next = 1'b1;
      af_next = 1'b0;
      bf_next = 1'b0;
      cf_next = 1'b0;
      count_next = '0;
      trig_seen_next = 1'b0;
    end
    if (disarm_write || !ctrl_next[dta_pkg::DTA_C_EN]) begin
      capture_active_flag_next = 1'b0;
    end
  end

  // Reset keeps end-trace results while enabled but ends the run
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      if (reset_keep) begin
        ctrl_reg[dta_pkg::DTA_C_ARM] <= 1'b0;
        ctrl_reg[dta_pkg::DTA_C_BRK] <= 1'b0;
        capture_active_flag_reg <= 1'b0;
      end else begin
        ctrl_reg <= 8'h00;
        trig_reg <= 8'h00;
        mode_reg <= dta_pkg::DTA_MODE_A_ONLY;
        cmpa_reg <= '0;
        cmpb_reg <= '0;
        af_reg <= 1'b0;
        bf_reg <= 1'b0;
        cf_reg <= 1'b0;
        capture_active_flag_reg <= 1'b0;
        count_reg <= '0;
      end
      seq_reg <= 1'b0;
      trig_seen_reg <= 1'b0;
      store_valid <= 1'b0;
      store_value <= '0;
      store_event_data <= 1'b0;
      halt_force <= 1'b0;
      halt_tag <= 1'b0;
      prev_addr_reg <= '0;
    end else begin
      ctrl_reg <= ctrl_next;
      trig_reg <= trig_next;
      mode_reg <= mode_next;
      cmpa_reg <= cmpa_next;
      cmpb_reg <= cmpb_next;
      af_reg <= af_next;
      bf_reg <= bf_next;
      cf_reg <= cf_next;
      capture_active_flag_reg <= capture_active_flag_next;
      count_reg <= count_next;
      seq_reg <= seq_next;
      trig_seen_reg <= trig_seen_next;
      store_valid <= store_valid_next;
      store_value <= store_value_next;
      store_event_data <= store_event_next;
      halt_force <= halt_force_next;
      halt_tag <= halt_tag_next;
      prev_addr_reg <= core_bus_valid ? core_addr : prev_addr_reg;
    end
  end

  // AXI4-Lite slave, one write and one read at a time
  assign s_axi_awready = !aw_got_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_got_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    aw_got_next = aw_got_reg;
    w_got_next = w_got_reg;
    awaddr_next = awaddr_reg;
    wbyte_next = wbyte_reg;
    wstrb0_next = wstrb0_reg;
    bvalid_next = s_axi_bvalid && !s_axi_bready;
    bresp_next = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_got_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_got_next = 1'b1;
      wbyte_next = s_axi_wdata;
      wstrb0_next = s_axi_wstrb[0];
    end
    if (wr_fire) begin
      aw_got_next = 1'b0;
      w_got_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = (awaddr_reg == dta_pkg::DTA_OFF_CTRL ||
                    awaddr_reg == dta_pkg::DTA_OFF_TRIG ||
                    awaddr_reg == dta_pkg::DTA_OFF_CMPA ||
                    awaddr_reg == dta_pkg::DTA_OFF_CMPB) ?
                   dta_pkg::DTA_RESP_OKAY : dta_pkg::DTA_RESP_SLVERR;
    end
  end

  always_comb begin
    rvalid_next = s_axi_rvalid && !s_axi_rready;
    rdata_next = s_axi_rdata;
    rresp_next = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next = dta_pkg::DTA_RESP_OKAY;
      rdata_next = 32'h0000_0000;
      case (s_axi_araddr)
        dta_pkg::DTA_OFF_CTRL: rdata_next[7:0] = ctrl_reg;
        dta_pkg::DTA_OFF_TRIG: rdata_next[7:0] = trig_reg | {4'h0, mode_reg};
        dta_pkg::DTA_OFF_STAT: rdata_next[7:0] =
          {af_reg, bf_reg, cf_reg, 2'h0, capture_active_flag_reg, 2'h0};
        dta_pkg::DTA_OFF_CMPA: rdata_next = 32'(cmpa_reg);
        dta_pkg::DTA_OFF_CMPB: rdata_next = 32'(cmpb_reg);
        dta_pkg::DTA_OFF_COUNT: rdata_next = 32'(count_reg);
        default: rresp_next = dta_pkg::DTA_RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wbyte_reg <= 32'h0000_0000;
      wstrb0_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= dta_pkg::DTA_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= dta_pkg::DTA_RESP_OKAY;
    end else begin
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      awaddr_reg <= awaddr_next;
      wbyte_reg <= wbyte_next;
      wstrb0_reg <= wstrb0_next;
      s_axi_bvalid <= bvalid_next;
      s_axi_bresp <= bresp_next;
      s_axi_rvalid <= rvalid_next;
      s_axi_rdata <= rdata_next;
      s_axi_rresp <= rresp_next;
    end
  end

  a_arm_clears: assert property (arm_write |=> capture_active_flag_reg &&
    !af_reg && !bf_reg && !cf_reg)
    else $error("arming did not set active and clear flags");
  a_end_disarm: assert property (armed && !begin_type && trigger &&
    !arm_write |=> !capture_active_flag_reg)
    else $error("end trigger did not disarm");
  a_disable_drops: assert property (!enable |-> !capture_active_flag_reg)
    else $error("active flag set while disabled");
  a_flags_sticky: assert property (af_reg && !arm_write |=> af_reg)
    else $error("flag one dropped without rearm");
  a_force_halt: assert property (armed && !begin_type && trigger &&
    brk && !tag |=> halt_force)
    else $error("missing forced halt at end trigger");
  a_tag_halt: assert property (halt_tag |-> $past(tag) && $past(brk))
    else $error("tagged halt without enable");
  a_seq_order: assert property (!seq_reg &&
    (mode_reg == dta_pkg::DTA_MODE_A_THEN_B) |-> !set_b)
    else $error("second comparator evaluated first");
  a_count_limit: assert property (count_reg <= CNT_W'(DEPTH))
    else $error("storage count beyond depth");
  a_event_begin: assert property (armed && event_mode && set_b &&
    !wr_fire && count_reg < CNT_W'(DEPTH - 1) |=> capture_active_flag_reg)
    else $error("event trigger ended the run");
  c_end_run: cover property (@(posedge clk_sys) armed ##1 !capture_active_flag_reg);
  c_begin_full: cover property (@(posedge clk_sys) full && begin_type);
  c_halt: cover property (@(posedge clk_sys) halt_force);
endmodule

/* File: design/dta_pkg.sv */
// Constants for the debug trigger arming and trigger-mode controller
package dta_pkg;
  localparam logic [3:0] DTA_MODE_A_ONLY = 4'h0;
  localparam logic [3:0] DTA_MODE_A_OR_B = 4'h1;
  localparam logic [3:0] DTA_MODE_A_THEN_B = 4'h2;
  localparam logic [3:0] DTA_MODE_EVENT_B = 4'h3;
  localparam logic [3:0] DTA_MODE_A_THEN_EVB = 4'h4;
  localparam logic [3:0] DTA_MODE_A_AND_B = 4'h5;
  localparam logic [3:0] DTA_MODE_A_AND_NB = 4'h6;
  localparam logic [3:0] DTA_MODE_INSIDE = 4'h7;
  localparam logic [3:0] DTA_MODE_OUTSIDE = 4'h8;
  localparam logic [3:0] DTA_MODE_LAST = 4'h8;
  localparam int DTA_DEPTH = 8;
  localparam logic [7:0] DTA_OFF_CTRL = 8'h00;
  localparam logic [7:0] DTA_OFF_TRIG = 8'h04;
  localparam logic [7:0] DTA_OFF_STAT = 8'h08;
  localparam logic [7:0] DTA_OFF_CMPA = 8'h0C;
  localparam logic [7:0] DTA_OFF_CMPB = 8'h10;
  localparam logic [7:0] DTA_OFF_COUNT = 8'h14;
  // Control register bits
  localparam int DTA_C_EN = 7;
  localparam int DTA_C_ARM = 6;
  localparam int DTA_C_TAG = 5;
  localparam int DTA_C_BRK = 4;
  // Trigger register bits
  localparam int DTA_T_QUAL = 7;
  localparam int DTA_T_BEGIN = 6;
  // Status register bits
  localparam int DTA_S_AF = 7;
  localparam int DTA_S_BF = 6;
  localparam int DTA_S_CF = 5;
  localparam int DTA_S_CAPTURE_ACTIVE_FLAG = 2;
  localparam logic [1:0] DTA_RESP_OKAY = 2'h0;
  localparam logic [1:0] DTA_RESP_SLVERR = 2'h2;
endpackage

/* File: verification/dta_cpu_model.sv */
// CPU core bus model driving the watch inputs of the trigger controller
`timescale 1ns/1ps
module dta_cpu_model #(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 8
) (
  input wire logic clk_sys,
  output logic [ADDR_W-1:0] core_addr,
  output logic [DATA_W-1:0] core_data,
  output logic core_bus_valid,
  output logic [1:0] core_cof,
  output logic opcode_exec_a,
  output logic opcode_exec_b
);
  initial begin
    core_addr = '0;
    core_data = '0;
    core_bus_valid = 1'b0;
    core_cof = 2'b00;
    opcode_exec_a = 1'b0;
    opcode_exec_b = 1'b0;
  end

  // One bus cycle, then an idle cycle with the buses showing inverted junk
  task automatic bus(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     input logic [1:0] cof, input logic exa, input logic exb);
    core_addr <= a;
    core_data <= d;
    core_bus_valid <= 1'b1;
    core_cof <= cof;
    opcode_exec_a <= exa;
    opcode_exec_b <= exb;
    @(posedge clk_sys);
    core_addr <= ~a;
    core_data <= ~d;
    core_bus_valid <= 1'b0;
    core_cof <= 2'b00;
    opcode_exec_a <= 1'b0;
    opcode_exec_b <= 1'b0;
    @(posedge clk_sys);
  endtask
endmodule

/* File: verification/debug_trigger_arm_control_tb_top.sv */
// Self-checking bench for the trigger, arming and halt controller
`timescale 1ns/1ps
module debug_trigger_arm_control_tb_top;
  logic clk_sys, reset;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [15:0] core_addr, store_value, last_val;
  logic [7:0] core_data;
  logic [1:0] core_cof;
  logic core_bus_valid, opcode_exec_a, opcode_exec_b;
  logic store_valid, store_event_data, halt_force, halt_tag, last_ev;
  logic [31:0] rd;
  logic [1:0] rr;
  int err_count, check_count, store_n, force_n, tag_n;

  dta_top dut_u (.clk_sys(clk_sys), .reset(reset),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .core_addr(core_addr),
    .core_data(core_data), .core_bus_valid(core_bus_valid),
    .core_cof(core_cof), .opcode_exec_a(opcode_exec_a),
    .opcode_exec_b(opcode_exec_b), .store_valid(store_valid),
    .store_value(store_value), .store_event_data(store_event_data),
    .halt_force(halt_force), .halt_tag(halt_tag));

  dta_cpu_model cpu_u (.clk_sys(clk_sys), .core_addr(core_addr),
    .core_data(core_data), .core_bus_valid(core_bus_valid),
    .core_cof(core_cof), .opcode_exec_a(opcode_exec_a),
    .opcode_exec_b(opcode_exec_b));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Pulses counted at the edge, so a one-cycle output is never missed
  always @(posedge clk_sys) begin
    if (store_valid === 1'b1) begin
      store_n++;
      last_val = store_value;
      last_ev = store_event_data;
    end
    if (halt_force === 1'b1) force_n++;
    if (halt_tag === 1'b1) tag_n++;
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check_val(input string name, input logic [31:0] exp,
                           input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_resp(input string name, input logic [1:0] exp,
                            input logic [1:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_sys);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    check_resp("bresp", dta_pkg::DTA_RESP_OKAY, r);
  endtask

  task automatic stat_is(input logic [7:0] mask, input logic [7:0] exp);
    axi_read(dta_pkg::DTA_OFF_STAT, rd, rr);
    check_val("status", {24'h0, exp}, rd & {24'h0, mask});
  endtask

  // Disarm first so every call starts a fresh run
  task automatic arm(input logic [7:0] t, input logic [7:0] c);
    wr(dta_pkg::DTA_OFF_CTRL, 32'h80);
    wr(dta_pkg::DTA_OFF_TRIG, {24'h0, t});
    wr(dta_pkg::DTA_OFF_CTRL, {24'h0, c});
    stat_is(8'hE4, 8'h04);
    store_n = 0;
    force_n = 0;
    tag_n = 0;
  endtask

  task automatic row(input logic [3:0] m, input logic [15:0] a1,
                     input logic [7:0] d1, input logic [15:0] a2,
                     input logic [7:0] d2, input logic [7:0] e);
    arm({4'h0, m}, 8'hC0);
    cpu_u.bus(a1, d1, 2'b00, 1'b0, 1'b0);
    cpu_u.bus(a2, d2, 2'b00, 1'b0, 1'b0);
    stat_is(8'hE4, e);
  endtask

  initial begin
    #2000000;
    err_count++;
    end_of_test();
  end

  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'b000;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    s_axi_wstrb = 4'hF;
    reset = 1'b1;
    {err_count, check_count, store_n, force_n, tag_n} = '0;
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    wr(dta_pkg::DTA_OFF_CMPA, 32'h1000);
    wr(dta_pkg::DTA_OFF_CMPB, 32'h20A5);
    row(4'h0, 16'h1000, 8'h11, 16'h1000, 8'h11, 8'h80);
    row(4'h0, 16'h20A5, 8'h11, 16'h20A5, 8'h11, 8'h04);
    row(4'h1, 16'h20A5, 8'h11, 16'h20A5, 8'h11, 8'h40);
    row(4'h2, 16'h20A5, 8'h11, 16'h20A5, 8'h11, 8'h04);
    row(4'h2, 16'h1000, 8'h11, 16'h20A5, 8'h11, 8'hC0);
    row(4'h3, 16'h20A5, 8'h5A, 16'h20A5, 8'h5A, 8'h44);
    check_val("event_flag", 32'h1, {31'h0, last_ev});
    check_val("event_value", 32'h005A, {16'h0, last_val});
    row(4'h4, 16'h20A5, 8'h5A, 16'h20A5, 8'h5A, 8'h04);
    row(4'h4, 16'h1000, 8'h11, 16'h20A5, 8'h5A, 8'hC4);
    row(4'h5, 16'h1000, 8'hA5, 16'h1000, 8'hA5, 8'hC0);
    row(4'h5, 16'h1000, 8'h11, 16'h20A5, 8'hA5, 8'h04);
    row(4'h6, 16'h1000, 8'h11, 16'h1000, 8'h11, 8'hC0);
    row(4'h6, 16'h1000, 8'hA5, 16'h1000, 8'hA5, 8'h04);
    row(4'h7, 16'h20A5, 8'h11, 16'h20A5, 8'h11, 8'hC0);
    row(4'h7, 16'h0FFF, 8'h11, 16'h20A6, 8'h11, 8'h04);
    row(4'h8, 16'h0FFF, 8'h11, 16'h0FFF, 8'h11, 8'h80);
    row(4'h8, 16'h20A6, 8'h11, 16'h20A6, 8'h11, 8'h40);
    row(4'h8, 16'h1000, 8'h11, 16'h20A5, 8'h11, 8'h04);
    // Begin run: trigger, then nine flow stores; the ninth must be dropped
    arm(8'h40, 8'hD0);
    cpu_u.bus(16'h1000, 8'h11, 2'b00, 1'b0, 1'b0);
    for (int i = 0; i < 9; i++) begin
      cpu_u.bus(16'(16'h3000 + i), 8'h00, 2'b10, 1'b0, 1'b0);
    end
    repeat (3) @(posedge clk_sys);
    check_val("stores", 32'd8, store_n);
    check_val("flow_value", 32'h3007, {16'h0, last_val});
    check_val("flow_flag", 32'h0, {31'h0, last_ev});
    check_val("force_halts", 32'd1, force_n);
    stat_is(8'hE4, 8'h80);
    axi_read(dta_pkg::DTA_OFF_COUNT, rd, rr);
    check_val("count", 32'd8, rd);
    arm(8'h00, 8'hD0);
    cpu_u.bus(16'h2224, 8'h00, 2'b00, 1'b0, 1'b0);
    cpu_u.bus(16'h3333, 8'h00, 2'b01, 1'b0, 1'b0);
    cpu_u.bus(16'h1000, 8'h11, 2'b00, 1'b0, 1'b0);
    repeat (3) @(posedge clk_sys);
    check_val("force_halts", 32'd1, force_n);
    check_val("tag_halts", 32'd0, tag_n);
    check_val("cof0_value", 32'h2222, {16'h0, last_val});
    check_val("stores", 32'd1, store_n);
    // Opcode qualified, tag halt: match alone must not trigger
    arm(8'h80, 8'hF0);
    cpu_u.bus(16'h1000, 8'h11, 2'b00, 1'b0, 1'b0);
    stat_is(8'h04, 8'h04);
    cpu_u.bus(16'h1000, 8'h11, 2'b00, 1'b1, 1'b0);
    repeat (3) @(posedge clk_sys);
    check_val("tag_halts", 32'd1, tag_n);
    check_val("force_halts", 32'd0, force_n);
    stat_is(8'h04, 8'h00);
    arm(8'h85, 8'hF0);
    cpu_u.bus(16'h1000, 8'h11, 2'b00, 1'b1, 1'b0);
    repeat (3) @(posedge clk_sys);
    check_val("tag_halts", 32'd1, tag_n);
    arm(8'h01, 8'hD0);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    axi_read(dta_pkg::DTA_OFF_CTRL, rd, rr);
    check_val("ctrl", 32'h80, rd & 32'hFF);
    axi_read(dta_pkg::DTA_OFF_TRIG, rd, rr);
    check_val("trig", 32'h01, rd & 32'hFF);
    stat_is(8'h04, 8'h00);
    arm(8'h00, 8'hC0);
    wr(dta_pkg::DTA_OFF_CTRL, 32'h80);
    stat_is(8'h04, 8'h00);
    arm(8'h00, 8'hC0);
    wr(dta_pkg::DTA_OFF_CTRL, 32'h40);
    stat_is(8'h04, 8'h00);
    axi_read(8'h40, rd, rr);
    check_resp("rresp", dta_pkg::DTA_RESP_SLVERR, rr);
    axi_write(dta_pkg::DTA_OFF_STAT, 32'hFF, rr);
    check_resp("bresp", dta_pkg::DTA_RESP_SLVERR, rr);
    end_of_test();
  end
endmodule
